// ===== logic/erm_average.v
// moving-average history of up to ten period results
`timescale 1ns/1ps
module erm_average
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire clear,
   input wire push,
   input wire [3:0] depth,
   input wire signed [31:0] din,
   output reg signed [35:0] sum,
   output reg [3:0] fill
);
   reg signed [31:0] hist [0:9];
   integer i;

   // newest at index zero; fill saturates at the configured depth
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fill <= 4'h0;
         for (i = 0; i < 10; i = i + 1)
            hist[i] <= 32'h00000000;
      end
      else if (ce)
      begin
         if (clear)
            fill <= 4'h0;
         else if (push)
         begin
            hist[0] <= din;
            for (i = 1; i < 10; i = i + 1)
               hist[i] <= hist[i-1];
            fill <= (fill < depth) ? fill + 4'h1 : depth;
         end
      end
   end

   // only the filled part of the history is summed
   always @*
   begin
      sum = 36'h000000000;
      for (i = 0; i < 10; i = i + 1)
         if (i < fill)
            sum = sum + {{4{hist[i][31]}}, hist[i]};
   end
endmodule // erm_average

// ===== logic/erm_consts.vh
// constants for the encoder rate meter: offsets, fields, resets, limits, timing
`ifndef ERM_CONSTS_VH
`define ERM_CONSTS_VH
// register byte offsets
`define ERM_A_CTRL 8'h00
`define ERM_A_SEL 8'h04
`define ERM_A_CPR 8'h08
`define ERM_A_PERIOD 8'h0C
`define ERM_A_DEPTH 8'h10
`define ERM_A_STATUS 8'h14
`define ERM_A_FREQ 8'h18
`define ERM_A_SPEED 8'h1C
// field positions
`define ERM_CTRL_RUN 0
`define ERM_CTRL_RELOAD 1
`define ERM_ST_ACTIVE 0
`define ERM_ST_FAULT 1
// reset values
`define ERM_RST_SLOT 8'h00
`define ERM_RST_CHAN 8'h01
`define ERM_RST_CPR 32'h00000001
`define ERM_RST_PERIOD 16'h0001
`define ERM_RST_DEPTH 16'h0001
// accepted ranges
`define ERM_SLOT_MAX 8'h1F
`define ERM_CHAN_1 8'h01
`define ERM_CHAN_2 8'h02
`define ERM_PERIOD_MAX 16'h03E8
`define ERM_DEPTH_MAX 16'h000A
// fault codes
`define ERM_F_NONE 8'h00
`define ERM_F_PERIOD 8'h01
`define ERM_F_CPR 8'h02
`define ERM_F_DEPTH 8'h03
`define ERM_F_SLOT 8'h04
`define ERM_F_CHAN 8'h05
// scaling: milliseconds per second, and that times seconds per minute
`define ERM_HZ_SCALE 48'h0000000003E8
`define ERM_RPM_SCALE 48'h00000000EA60
// timing
`define ERM_MS_NS 1000000
`define ERM_CLK_NS 40
`endif

// ===== logic/erm_divider.v
// serial signed-by-unsigned divider with saturation to 32 signed bits
`timescale 1ns/1ps
module erm_divider
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire start,
   input wire signed [47:0] num,
   input wire [47:0] den,
   output reg done,
   output reg signed [31:0] quo
);
   reg [47:0] rem;
   reg [47:0] q;
   reg [47:0] den_r;
   reg neg;
   reg busy;
   reg [5:0] steps;
   wire [48:0] trial = {rem, q[47]};
   wire [48:0] diff = trial - {1'b0, den_r};
   wire [31:0] mag = (q[47:31] != 17'h00000) ? 32'h7FFFFFFF : {1'b0, q[30:0]};

   // one quotient bit per cycle; 48 cycles plus one to finish
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rem <= 48'h000000000000;
         q <= 48'h000000000000;
         den_r <= 48'h000000000000;
         neg <= 1'b0;
         busy <= 1'b0;
         steps <= 6'h00;
         done <= 1'b0;
         quo <= 32'h00000000;
      end
      else if (ce)
      begin
         done <= 1'b0;
         if (start)
         begin
            neg <= num[47];
            q <= num[47] ? (48'h000000000000 - num) : num;
            den_r <= den;
            rem <= 48'h000000000000;
            steps <= 6'h00;
            busy <= 1'b1;
         end
         else if (busy)
         begin
            if (steps == 6'h30)
            begin
               // truncates toward zero, saturating rather than wrapping
               quo <= neg ? (32'h00000000 - mag) : mag;
               done <= 1'b1;
               busy <= 1'b0;
            end
            else
            begin
               rem <= diff[48] ? trial[47:0] : diff[47:0];
               q <= {q[46:0], ~diff[48]};
               steps <= steps + 6'h01;
            end
         end
      end
   end
endmodule // erm_divider

// ===== logic/erm_rate_meter.v
// encoder rate meter: APB registers, sampling timer and result sequencing
//
// Behaviour
// - active flag follows run enable edges
// - new results after every completed sampling period
// - frequency is count difference per second
// - speed is difference times 60 per revolution-second
// - sampling period 1 to 1000 ms, else fault
// - counts per revolution zero is a fault
// - averaging depth 1 to 10 results
// - parameters captured on run enable rising
// - reload request applies parameters, then self-clears
// - disabled: results hold their last values
// - fault flag and code clear on disable
// - module slot 0 to 31 accepted
// - channel must be 1 or 2
// - cleared or overwritten counts give disturbed results
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "erm_consts.vh"
module erm_rate_meter
#(
   parameter CYC_PER_MS = `ERM_MS_NS / `ERM_CLK_NS
)
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [31:0] present_count_ch1,
   input wire [31:0] present_count_ch2,
   output reg active_flag,
   output reg fault_flag
);
   localparam S_IDLE = 2'b00;
   localparam S_RUN = 2'b01;
   localparam S_DIV = 2'b10;
   localparam S_FAULT = 2'b11;

   // software-side settings
   reg run_enable;
   reg param_reload_request;
   reg [7:0] module_slot_select;
   reg [7:0] channel_select;
   reg [31:0] counts_per_revolution;
   reg [15:0] sample_period_ms;
   reg [15:0] average_depth;
   // settings in force
   reg [7:0] act_chan;
   reg [31:0] act_cpr;
   reg [15:0] act_period;
   reg [3:0] act_depth;
   // status and results
   reg [7:0] fault_code;
   reg signed [31:0] freq_result;
   reg signed [31:0] speed_result;
   // sequencing
   reg run_prev;
   reg [1:0] state;
   reg [1:0] op;
   reg [31:0] ms_cnt;
   reg [15:0] per_cnt;
   reg [31:0] start_count;
   reg signed [31:0] count_diff;
   reg div_start;
   reg avg_clear;
   reg push_f;
   reg push_s;
   reg [47:0] div_num;
   reg [47:0] div_den;
   reg [31:0] next_rdata;
   reg next_err;

   wire div_done;
   wire signed [31:0] div_quo;
   wire signed [35:0] sum_f;
   wire signed [35:0] sum_s;
   wire [3:0] fill_f;
   wire [3:0] fill_s;

   wire wr_take = psel & penable & pready & pwrite;
   wire rd_phase = psel & penable & ~pready;
   wire [31:0] count_now = (act_chan == `ERM_CHAN_2) ? present_count_ch2 : present_count_ch1;
   wire [31:0] count_cap = (channel_select == `ERM_CHAN_2) ? present_count_ch2 : present_count_ch1;
   wire running = (state == S_RUN) || (state == S_DIV);
   wire ms_end = (ms_cnt == CYC_PER_MS - 1);
   wire period_end = running && ms_end && (per_cnt == act_period - 16'h0001);
   wire [7:0] chk_code = erm_check(sample_period_ms, counts_per_revolution, average_depth,
      module_slot_select, channel_select);
   wire [47:0] diff_x = {{16{count_diff[31]}}, count_diff};
   // an accepted reload, decoded where the control process applies it
   wire reload_go = (state == S_RUN) && run_enable && run_prev && param_reload_request &&
      (chk_code == `ERM_F_NONE);

   // range check shared by start-up and reload; first failure wins
   function [7:0] erm_check;
      input [15:0] per;
      input [31:0] cpr;
      input [15:0] dep;
      input [7:0] slot;
      input [7:0] ch;
      begin
         if (per == 16'h0000 || per > `ERM_PERIOD_MAX)
            erm_check = `ERM_F_PERIOD;
         else if (cpr == 32'h00000000)
            erm_check = `ERM_F_CPR;
         else if (dep == 16'h0000 || dep > `ERM_DEPTH_MAX)
            erm_check = `ERM_F_DEPTH;
         else if (slot > `ERM_SLOT_MAX)
            erm_check = `ERM_F_SLOT;
         else if (ch != `ERM_CHAN_1 && ch != `ERM_CHAN_2)
            erm_check = `ERM_F_CHAN;
         else
            erm_check = `ERM_F_NONE;
      end
   endfunction

   // one divider serves all four quotients in turn
   always @*
   begin
      case (op)
         2'd0:
         begin
            div_num = diff_x * `ERM_HZ_SCALE;
            div_den = {32'h00000000, act_period};
         end
         2'd1:
         begin
            div_num = diff_x * `ERM_RPM_SCALE;
            div_den = {16'h0000, act_cpr} * {32'h00000000, act_period};
         end
         2'd2:
         begin
            div_num = {{12{sum_f[35]}}, sum_f};
            div_den = {44'h00000000000, fill_f};
         end
         default:
         begin
            div_num = {{12{sum_s[35]}}, sum_s};
            div_den = {44'h00000000000, fill_s};
         end
      endcase
   end

   erm_divider u_div
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .done(div_done),
      .quo(div_quo)
   );

   erm_average u_avg_f
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(avg_clear),
      .push(push_f),
      .depth(act_depth),
      .din(div_quo),
      .sum(sum_f),
      .fill(fill_f)
   );

   erm_average u_avg_s
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(avg_clear),
      .push(push_s),
      .depth(act_depth),
      .din(div_quo),
      .sum(sum_s),
      .fill(fill_s)
   );

   // read mux; an unmapped address answers zero with an error
   always @*
   begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      case (paddr)
         `ERM_A_CTRL:
         begin
            next_rdata[`ERM_CTRL_RUN] = run_enable;
            next_rdata[`ERM_CTRL_RELOAD] = param_reload_request;
         end
         `ERM_A_SEL:
            next_rdata = {16'h0000, channel_select, module_slot_select};
         `ERM_A_CPR:
            next_rdata = counts_per_revolution;
         `ERM_A_PERIOD:
            next_rdata = {16'h0000, sample_period_ms};
         `ERM_A_DEPTH:
            next_rdata = {16'h0000, average_depth};
         `ERM_A_STATUS:
         begin
            next_rdata[`ERM_ST_ACTIVE] = active_flag;
            next_rdata[`ERM_ST_FAULT] = fault_flag;
            next_rdata[15:8] = fault_code;
         end
         `ERM_A_FREQ:
            next_rdata = freq_result;
         `ERM_A_SPEED:
            next_rdata = speed_result;
         default:
            next_err = 1'b1;
      endcase
   end

   // apb slave: one wait state, answer registered so outputs come from flops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready <= rd_phase;
         if (rd_phase)
         begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
         end
         else
         begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   // plain settings; writes land at the edge that samples pready high
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_slot_select <= `ERM_RST_SLOT;
         channel_select <= `ERM_RST_CHAN;
         counts_per_revolution <= `ERM_RST_CPR;
         sample_period_ms <= `ERM_RST_PERIOD;
         average_depth <= `ERM_RST_DEPTH;
      end
      else if (ce && wr_take)
      begin
         case (paddr)
            `ERM_A_SEL:
            begin
               module_slot_select <= pwdata[7:0];
               channel_select <= pwdata[15:8];
            end
            `ERM_A_CPR:
               counts_per_revolution <= pwdata;
            `ERM_A_PERIOD:
               sample_period_ms <= pwdata[15:0];
            `ERM_A_DEPTH:
               average_depth <= pwdata[15:0];
            default:
               module_slot_select <= module_slot_select;
         endcase
      end
   end

   // millisecond and period timers run only while measuring; they restart on the
   // same edge that takes the start count, so the first period is a whole period long
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_cnt <= 32'h00000000;
         per_cnt <= 16'h0000;
      end
      else if (ce)
      begin
         if (!running || reload_go)
         begin
            ms_cnt <= 32'h00000000;
            per_cnt <= 16'h0000;
         end
         else if (ms_end)
         begin
            ms_cnt <= 32'h00000000;
            per_cnt <= period_end ? 16'h0000 : per_cnt + 16'h0001;
         end
         else
            ms_cnt <= ms_cnt + 32'h00000001;
      end
   end

   // control, start-up, reload and the result sequence
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_enable <= 1'b0;
         param_reload_request <= 1'b0;
         run_prev <= 1'b0;
         state <= S_IDLE;
         op <= 2'd0;
         act_chan <= `ERM_RST_CHAN;
         act_cpr <= `ERM_RST_CPR;
         act_period <= `ERM_RST_PERIOD;
         act_depth <= 4'h1;
         active_flag <= 1'b0;
         fault_flag <= 1'b0;
         fault_code <= `ERM_F_NONE;
         freq_result <= 32'h00000000;
         speed_result <= 32'h00000000;
         start_count <= 32'h00000000;
         count_diff <= 32'h00000000;
         div_start <= 1'b0;
         avg_clear <= 1'b0;
         push_f <= 1'b0;
         push_s <= 1'b0;
      end
      else if (ce)
      begin
         div_start <= 1'b0;
         avg_clear <= 1'b0;
         push_f <= 1'b0;
         push_s <= 1'b0;
         run_prev <= run_enable;
         if (wr_take && paddr == `ERM_A_CTRL)
            run_enable <= pwdata[`ERM_CTRL_RUN];
         if (run_enable && !run_prev)
         begin
            active_flag <= 1'b1;
            if (chk_code != `ERM_F_NONE)
            begin
               fault_flag <= 1'b1;
               fault_code <= chk_code;
               state <= S_FAULT;
            end
            else
            begin
               act_chan <= channel_select;
               act_cpr <= counts_per_revolution;
               act_period <= sample_period_ms;
               act_depth <= average_depth[3:0];
               start_count <= count_cap;
               avg_clear <= 1'b1;
               op <= 2'd0;
               state <= S_RUN;
            end
         end
         else if (!run_enable && run_prev)
         begin
            // results are left as they are
            active_flag <= 1'b0;
            fault_flag <= 1'b0;
            fault_code <= `ERM_F_NONE;
            state <= S_IDLE;
         end
         else
         begin
            if (period_end)
            begin
               // a cleared or rewritten counter is not corrected for
               count_diff <= count_now - start_count;
               start_count <= count_now;
            end
            case (state)
               S_RUN:
               begin
                  if (param_reload_request)
                  begin
                     if (chk_code != `ERM_F_NONE)
                     begin
                        fault_flag <= 1'b1;
                        fault_code <= chk_code;
                     end
                     else
                     begin
                        act_chan <= channel_select;
                        act_cpr <= counts_per_revolution;
                        act_period <= sample_period_ms;
                        act_depth <= average_depth[3:0];
                        start_count <= count_cap;
                        avg_clear <= 1'b1;
                     end
                  end
                  else if (period_end)
                  begin
                     op <= 2'd0;
                     div_start <= 1'b1;
                     state <= S_DIV;
                  end
               end
               S_DIV:
               begin
                  if (div_done)
                  begin
                     push_f <= (op == 2'd0);
                     push_s <= (op == 2'd1);
                     if (op == 2'd2)
                        freq_result <= div_quo;
                     if (op == 2'd3)
                     begin
                        speed_result <= div_quo;
                        state <= S_RUN;
                     end
                     else
                     begin
                        op <= op + 2'd1;
                        div_start <= 1'b1;
                     end
                  end
               end
               default:
                  state <= state;
            endcase
         end
         // request clears once applied; a software write in that cycle wins
         if (wr_take && paddr == `ERM_A_CTRL)
            param_reload_request <= pwdata[`ERM_CTRL_RELOAD];
         else if (state == S_RUN && run_enable && run_prev)
            param_reload_request <= 1'b0;
         else if (run_enable && !run_prev)
            param_reload_request <= 1'b0;
      end
   end
endmodule // erm_rate_meter

// ===== verification/erm_count_model.sv
// counter channel model: running count with a fixed step per clock
`timescale 1ns/1ps
module erm_count_model
#(
   parameter [31:0] START = 32'h00000000,
   parameter [31:0] STEP = 32'h00000001
)
(
   input wire pclk,
   input wire presetn,
   output reg [31:0] count
);
   // counts from reset release on, so it is running before any enable;
   // the step is small, which keeps one period's displacement far below 2^31
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= START;
      else
         count <= count + STEP;
   end
endmodule // erm_count_model

// ===== verification/erm_rate_meter_sva.sv
// checker for the rate meter ports: bus timing and run and fault flags
`timescale 1ns/1ps
module erm_rate_meter_sva
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire active_flag,
   input wire fault_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a completed write to the control word
   wire ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
   pready_pulse_a: assert property (pready && ce |=> !pready)
      else $error("pready longer than one cycle");
   pready_wait_a: assert property (psel && !penable && ce ##1 psel && penable && ce
      |-> !pready ##1 pready) else $error("pready not after one wait state");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   addr_err_a: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
      else $error("pslverr wrong for address");
   rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h00000000)
      else $error("prdata not zero outside a read");
   run_rise_a: assert property (ctrl_wr && pwdata[0] && !active_flag |-> ##[1:3] active_flag)
      else $error("active flag missed enable");
   run_fall_a: assert property (ctrl_wr && !pwdata[0] && active_flag
      |-> ##[1:3] (!active_flag && !fault_flag)) else $error("flags stay after disable");
   fault_active_a: assert property ($rose(fault_flag) |-> active_flag)
      else $error("fault raised while idle");
   ce_freeze_a: assert property (!ce |=> $stable(pready) && $stable(prdata)
      && $stable(active_flag) && $stable(fault_flag)) else $error("outputs moved with ce low");
   cover property (!ce && psel);
   cover property (ctrl_wr && pwdata[0] ##[1:3] fault_flag);
   cover property (pready && pslverr);
   cover property ($fell(active_flag));
endmodule // erm_rate_meter_sva

// ===== verification/tb.sv
// self-checking bench for the rate meter: parameter table, results, reload, bus errors
`timescale 1ns/1ps
bind erm_rate_meter erm_rate_meter_sva erm_rate_meter_sva_i (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .active_flag(active_flag),
   .fault_flag(fault_flag));
module tb;
   localparam CYC = 10;
   typedef struct {logic [7:0] slot, chan; logic [31:0] cpr; logic [15:0] per, dep, code;} erm_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, cnt1, cnt2, rd;
   logic pready, pslverr, active_flag, fault_flag, er;
   int fail_count = 0;
   int cmp_count = 0;
   int st;
   longint f, s;
   longint ps = 0;
   erm_row_t r;
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [31:0] rv[8] = '{32'h0, 32'h100, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
   // slot, channel, counts per rev, period, depth, expected fault code
   erm_row_t rows[12] = '{
      '{8'h00, 8'h01, 32'h000003E8, 16'h0002, 16'h0001, 16'h0000},
      '{8'h00, 8'h01, 32'h000003E8, 16'h0000, 16'h0001, 16'h0001},
      '{8'h00, 8'h01, 32'h000003E8, 16'h03E9, 16'h0001, 16'h0001},
      '{8'h00, 8'h01, 32'h00000000, 16'h0002, 16'h0001, 16'h0002},
      '{8'h00, 8'h01, 32'h000003E8, 16'h0002, 16'h0000, 16'h0003},
      '{8'h00, 8'h01, 32'h000003E8, 16'h0002, 16'h000B, 16'h0003},
      '{8'h20, 8'h01, 32'h000003E8, 16'h0002, 16'h0001, 16'h0004},
      '{8'h00, 8'h00, 32'h000003E8, 16'h0002, 16'h0001, 16'h0005},
      '{8'h00, 8'h03, 32'h000003E8, 16'h0002, 16'h0001, 16'h0005},
      '{8'h00, 8'h01, 32'h00000000, 16'h0000, 16'h0000, 16'h0001},
      '{8'h1F, 8'h02, 32'h00000007, 16'h0001, 16'h000A, 16'h0000},
      '{8'h05, 8'h01, 32'h00000001, 16'h03E8, 16'h000A, 16'h0000}};
   always #20 pclk = ~pclk;
   // ch1 wraps upward, ch2 counts down through zero
   erm_count_model #(.START(32'hFFFFFF00), .STEP(32'h00000005)) erm_count_model_i (
      .pclk(pclk), .presetn(presetn), .count(cnt1));
   erm_count_model #(.START(32'h00000010), .STEP(32'hFFFFFFFD)) erm_count_model_i_2 (
      .pclk(pclk), .presetn(presetn), .count(cnt2));
   erm_rate_meter #(.CYC_PER_MS(CYC)) erm_rate_meter_i (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .present_count_ch1(cnt1), .present_count_ch2(cnt2), .active_flag(active_flag),
      .fault_flag(fault_flag));
   task automatic print_verdict;
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one transfer; the request stands until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         print_verdict;
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h00000000);
      chk(rd, e);
      chk({31'h0, er}, {31'h0, ee});
   endtask
   // reads until the value shows up; a long wait is a failure
   task automatic poll(input logic [7:0] a, input logic [31:0] e);
      int n;
      n = 0;
      apb(1'b0, a, 32'h00000000);
      while (rd !== e && n < 4000)
      begin
         apb(1'b0, a, 32'h00000000);
         n++;
      end
      chk(rd, e);
      if (rd !== e)
         print_verdict;
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i])
         rdc(ra[i], rv[i], 1'b0);
      foreach (rows[i])
      begin
         r = rows[i];
         apb(1'b1, 8'h04, {16'h0000, r.chan, r.slot});
         apb(1'b1, 8'h08, r.cpr);
         apb(1'b1, 8'h0C, {16'h0000, r.per});
         apb(1'b1, 8'h10, {16'h0000, r.dep});
         rdc(8'h1C, ps[31:0], 1'b0);
         apb(1'b1, 8'h00, 32'h00000001);
         if (r.code != 16'h0000)
            rdc(8'h14, {8'h00, r.code, 8'h03}, 1'b0);
         else
         begin
            st = (r.chan == 8'h02) ? -3 : 5;
            f = longint'(st) * CYC * 1000;
            s = (longint'(st) * CYC * 60000) / longint'(r.cpr);
            poll(8'h1C, s[31:0]);
            rdc(8'h18, f[31:0], 1'b0);
            rdc(8'h14, 32'h00000001, 1'b0);
            ps = s;
         end
         apb(1'b1, 8'h00, 32'h00000000);
         rdc(8'h14, 32'h00000000, 1'b0);
      end
      // reload while running: new parameters land and the request clears itself
      apb(1'b1, 8'h00, 32'h00000001);
      apb(1'b1, 8'h08, 32'h000003E8);
      apb(1'b1, 8'h0C, 32'h00000002);
      apb(1'b1, 8'h10, 32'h00000001);
      apb(1'b1, 8'h00, 32'h00000003);
      poll(8'h00, 32'h00000001);
      poll(8'h1C, 32'h00000BB8);
      apb(1'b1, 8'h10, 32'h00000000);
      apb(1'b1, 8'h00, 32'h00000003);
      poll(8'h14, 32'h00000303);
      // clock enable low stalls the slave; the transfer waits it out
      ce <= 1'b0;
      fork
         rdc(8'h14, 32'h00000303, 1'b0);
         begin
            repeat (6) @(posedge pclk);
            ce <= 1'b1;
         end
      join
      apb(1'b1, 8'h00, 32'h00000000);
      rdc(8'h14, 32'h00000000, 1'b0);
      // unmapped, misaligned and read-only places
      rdc(8'h20, 32'h00000000, 1'b1);
      rdc(8'h02, 32'h00000000, 1'b1);
      apb(1'b1, 8'h14, 32'hFFFFFFFF);
      chk({31'h0, er}, 32'h00000000);
      rdc(8'h14, 32'h00000000, 1'b0);
      // reset while enabled clears flags, held results and settings
      apb(1'b1, 8'h00, 32'h00000001);
      repeat (5) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h14, 32'h00000000, 1'b0);
      rdc(8'h1C, 32'h00000000, 1'b0);
      rdc(8'h10, 32'h00000001, 1'b0);
      print_verdict;
   end
endmodule // tb
